// ---- hw/memory_bus_bridge.v ----
`timescale 1ns/1ps
`include "bridge_err_regs.vh"
module memory_bus_bridge #(
  parameter AW             = 32,
  parameter DW             = 32,
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input  wire          clock,       // 20 MHz clock.
  input  wire          rst_n,       // Asynchronous reset, active low.
  input  wire [7:0]    reg_addr,    // Register byte address.
  input  wire [31:0]   reg_wdata,   // Register write data.
  input  wire          reg_wr,      // Write strobe.
  input  wire          reg_rd,      // Read strobe.
  output reg  [31:0]   reg_rdata_q, // Read data, cycle after the strobe.
  input  wire          xfer_start,  // Internal-to-native transfer begins.
  input  wire          xfer_done,   // Transfer completed.
  input  wire          nxm_err,     // Master nonexistent memory pulse.
  input  wire [AW-1:0] fail_addr,   // Failing address.
  input  wire [3:0]    fail_region, // Failing address region.
  input  wire [DW-1:0] fail_data,   // Failing data.
  input  wire [2:0]    fail_port,   // Device port of the failure, 0 for none.
  input  wire          ca0_nxm_err, // Cache-A 0 nonexistent memory pulse.
  input  wire          ca1_nxm_err, // Cache-A 1 nonexistent memory pulse.
  output reg           nmi_q,       // Interrupt for unmasked events routed by nmi_select_q, level.
  output reg           bridge_interrupt_q, // Ordinary interrupt, level.
  output reg           timeout_q    // One-cycle timeout error pulse.
);
  reg         rs1_q;
  reg         rst_sync_n;
  reg  [31:0] control_status_reg_q;
  reg  [AW-1:0] error_address_reg_q;
  reg  [DW-1:0] error_data_reg_q;
  reg  [3:0]  error_region_q;
  reg  [31:0] region_select_reg_q;
  reg  [31:0] watchdog_port_enable_reg_q;
  reg  [31:0] timeout_limit_q;
  reg  [31:0] diag_status_q;
  reg  [3:0]  int_status_q;
  reg  [3:0]  int_mask_q;
  reg  [3:0]  nmi_select_q;
  reg  [31:0] wait_cnt_q;
  reg         busy_q;
  reg         held_q;
  wire [AW-1:0] ca0_addr;
  wire [DW-1:0] ca0_data;
  wire [AW-1:0] ca1_addr;
  wire [DW-1:0] ca1_data;
  wire        ca0_held;
  wire        ca1_held;
  wire        timeout_evt;
  wire        master_evt;
  wire [3:0]  events;
  wire [3:0]  pending;
  wire        rd_status;
  wire        rd_data;

  // Reset release is synchronised so that no flop leaves reset on a different edge.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q      <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rs1_q      <= 1'b1;
      rst_sync_n <= rs1_q;
    end
  end

  // Transfer watchdog on the internal-to-native path.
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      busy_q     <= 1'b0;
      wait_cnt_q <= 32'h00000000;
      timeout_q  <= 1'b0;
    end else begin
      timeout_q <= 1'b0;
      if (xfer_done) begin
        busy_q <= 1'b0;
      end else if (xfer_start) begin
        busy_q     <= 1'b1;
        wait_cnt_q <= 32'h00000000;
      end else if (busy_q) begin
        if (wait_cnt_q >= timeout_limit_q - 32'h00000001) begin
          busy_q    <= 1'b0;
          timeout_q <= 1'b1;
        end else begin
          wait_cnt_q <= wait_cnt_q + 32'h00000001;
        end
      end
    end
  end

  assign timeout_evt = busy_q && !xfer_done && !xfer_start &&
                       (wait_cnt_q >= timeout_limit_q - 32'h00000001);
  assign master_evt  = timeout_evt || nxm_err;
  assign events      = {ca1_nxm_err, ca0_nxm_err, nxm_err, timeout_evt};
  // A set mask bit silences its event; the status bit still records it for polling.
  assign pending     = int_status_q & ~int_mask_q;
  assign rd_status   = reg_rd && (reg_addr == `ADDR_INT_STATUS);
  assign rd_data     = reg_rd && (reg_addr == `ADDR_ERROR_DATA);

  // Master capture and registers.
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      control_status_reg_q       <= 32'h00000000;
      error_address_reg_q        <= {AW{1'b0}};
      error_data_reg_q           <= {DW{1'b0}};
      error_region_q             <= 4'h0;
      region_select_reg_q        <= `RSR_RESET;
      watchdog_port_enable_reg_q <= `WDR_RESET;
      timeout_limit_q            <= TIMEOUT_CYCLES;
      diag_status_q              <= 32'h00000000;
      int_status_q               <= 4'h0;
      int_mask_q                 <= 4'h0;
      nmi_select_q               <= 4'h0;
      held_q                     <= 1'b0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_CONTROL_STATUS: control_status_reg_q <= reg_wdata &
                                 ~(32'h00000007 << `CSR_PORT_LSB);
          `ADDR_REGION_SELECT:  region_select_reg_q <= reg_wdata;
          `ADDR_WATCHDOG_PORT:  watchdog_port_enable_reg_q <= reg_wdata;
          `ADDR_TIMEOUT_LIMIT:  timeout_limit_q <= (reg_wdata == 32'h00000000) ?
                                 32'h00000001 : reg_wdata;
          `ADDR_INT_MASK:       int_mask_q <= reg_wdata[3:0];
          `ADDR_NMI_SELECT:     nmi_select_q <= reg_wdata[3:0];
          default: ;
        endcase
      end
      // A new event in the same cycle as the clearing read survives.
      int_status_q <= (rd_status ? 4'h0 : int_status_q) | events;
      if (master_evt && (!held_q || rd_data)) begin
        held_q <= 1'b1;
        control_status_reg_q[`CSR_PORT_MSB:`CSR_PORT_LSB] <= fail_port;
        diag_status_q[`DSR_NMI_BIT] <= timeout_evt ? nmi_select_q[`IRQ_TIMEOUT] :
                                       nmi_select_q[`IRQ_NXM];
        if (nxm_err) begin
          error_address_reg_q <= fail_addr;
          error_region_q      <= fail_region;
        end
        error_data_reg_q <= fail_data;
      end else if (rd_data) begin
        held_q <= 1'b0;
      end
    end
  end

  cache_side_a_capture #(.AW(AW), .DW(DW)) u_ca0 (
    .clock       (clock),
    .rst_n       (rst_sync_n),
    .nxm_err     (ca0_nxm_err),
    .fail_addr   (fail_addr),
    .fail_data   (fail_data),
    .release_cap (reg_rd && (reg_addr == `ADDR_CA0_ERR_DATA)),
    .addr_q      (ca0_addr),
    .data_q      (ca0_data),
    .held_q      (ca0_held)
  );

  cache_side_a_capture #(.AW(AW), .DW(DW)) u_ca1 (
    .clock       (clock),
    .rst_n       (rst_sync_n),
    .nxm_err     (ca1_nxm_err),
    .fail_addr   (fail_addr),
    .fail_data   (fail_data),
    .release_cap (reg_rd && (reg_addr == `ADDR_CA1_ERR_DATA)),
    .addr_q      (ca1_addr),
    .data_q      (ca1_data),
    .held_q      ()
  );

  // Outputs and read data.
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata_q        <= 32'h00000000;
      nmi_q              <= 1'b0;
      bridge_interrupt_q <= 1'b0;
    end else begin
      nmi_q              <= |(pending & nmi_select_q);
      bridge_interrupt_q <= |(pending & ~nmi_select_q);
      reg_rdata_q        <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_CONTROL_STATUS:  reg_rdata_q <= control_status_reg_q;
          `ADDR_ERROR_ADDRESS:   reg_rdata_q <= error_address_reg_q;
          `ADDR_ERROR_DATA:      reg_rdata_q <= error_data_reg_q;
          `ADDR_ERROR_REGION:    reg_rdata_q <= {28'h0000000, error_region_q};
          `ADDR_REGION_SELECT:   reg_rdata_q <= region_select_reg_q;
          `ADDR_DIAG_STATUS:     reg_rdata_q <= diag_status_q;
          `ADDR_WATCHDOG_PORT:   reg_rdata_q <= watchdog_port_enable_reg_q;
          `ADDR_TIMEOUT_LIMIT:   reg_rdata_q <= timeout_limit_q;
          `ADDR_INT_STATUS:      reg_rdata_q <= {28'h0000000, int_status_q};
          `ADDR_INT_MASK:        reg_rdata_q <= {28'h0000000, int_mask_q};
          `ADDR_NMI_SELECT:      reg_rdata_q <= {28'h0000000, nmi_select_q};
          `ADDR_CA0_ERR_ADDRESS: reg_rdata_q <= ca0_addr;
          `ADDR_CA0_ERR_DATA:    reg_rdata_q <= ca0_data;
          `ADDR_CA1_ERR_ADDRESS: reg_rdata_q <= ca1_addr;
          `ADDR_CA1_ERR_DATA:    reg_rdata_q <= ca1_data;
          default:               reg_rdata_q <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ---- hw/bridge_err_regs.vh ----
`ifndef BRIDGE_ERR_REGS_VH
`define BRIDGE_ERR_REGS_VH
// Register byte addresses.
`define ADDR_CONTROL_STATUS  8'h00
`define ADDR_ERROR_ADDRESS   8'h04
`define ADDR_ERROR_DATA      8'h08
`define ADDR_ERROR_REGION    8'h0C
`define ADDR_REGION_SELECT   8'h10
`define ADDR_DIAG_STATUS     8'h14
`define ADDR_WATCHDOG_PORT   8'h18
`define ADDR_TIMEOUT_LIMIT   8'h1C
`define ADDR_INT_STATUS      8'h20
`define ADDR_INT_MASK        8'h24
`define ADDR_NMI_SELECT      8'h28
`define ADDR_CA0_ERR_ADDRESS 8'h30
`define ADDR_CA0_ERR_DATA    8'h34
`define ADDR_CA1_ERR_ADDRESS 8'h38
`define ADDR_CA1_ERR_DATA    8'h3C
// Field positions.
`define CSR_PORT_LSB         10
`define CSR_PORT_MSB         12
`define DSR_NMI_BIT          14
`define ERR_REGION_LSB       0
`define ERR_REGION_MSB       3
`define RSR_CA_REGION_LSB    8
`define RSR_CA_REGION_MSB    11
`define WDR_PORT_LSB         26
`define WDR_PORT_MSB         30
// Interrupt status bits.
`define IRQ_TIMEOUT          0
`define IRQ_NXM              1
`define IRQ_CA0_NXM          2
`define IRQ_CA1_NXM          3
// Reset values and timing.
`define TIMEOUT_US           10
`define CLOCK_MHZ            20
`define TIMEOUT_CYCLES       (`TIMEOUT_US * `CLOCK_MHZ)
`define RSR_RESET            32'h00000000
`define WDR_RESET            32'h00000000
`endif

// ---- hw/cache_side_a_capture.v ----
`timescale 1ns/1ps
module cache_side_a_capture #(
  parameter AW = 32,
  parameter DW = 32
) (
  input  wire          clock,       // System clock.
  input  wire          rst_n,       // Synchronised reset, active low.
  input  wire          nxm_err,     // Nonexistent memory pulse.
  input  wire [AW-1:0] fail_addr,   // Address of the failing transfer.
  input  wire [DW-1:0] fail_data,   // Data of the failing transfer.
  input  wire          release_cap, // Firmware read of the data capture.
  output reg  [AW-1:0] addr_q,      // Error address capture.
  output reg  [DW-1:0] data_q,      // Error data capture.
  output reg           held_q       // Capture is locked.
);
  // The first error wins; later ones only raise the interrupt until firmware reads.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= {AW{1'b0}};
      data_q <= {DW{1'b0}};
      held_q <= 1'b0;
    end else if (nxm_err && (!held_q || release_cap)) begin
      addr_q <= fail_addr;
      data_q <= fail_data;
      held_q <= 1'b1;
    end else if (release_cap) begin
      held_q <= 1'b0;
    end
  end
endmodule

// ---- tb/bridge_err_checker_assertions.sv ----
`timescale 1ns/1ps
module bridge_err_checker (
  input wire        clock,
  input wire        rst_n,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire        xfer_done,
  input wire        nxm_err,
  input wire        ca0_nxm_err,
  input wire        ca1_nxm_err,
  input wire        nmi_q,
  input wire        bridge_interrupt_q,
  input wire        timeout_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reg  [3:0] mask_q;
  reg  [3:0] sel_q;
  reg  [1:0] cfg_q;
  wire       err = nxm_err | ca0_nxm_err | ca1_nxm_err;
  wire       irq = nmi_q | bridge_interrupt_q;
  // Mask and select copies mean nothing until firmware has written both.
  always @(posedge clock or negedge rst_n)
    if (!rst_n) cfg_q <= 2'h0;
    else if (reg_wr) cfg_q <= cfg_q | {reg_addr == 8'h28, reg_addr == 8'h24};
  always @(posedge clock)
    if (reg_wr && reg_addr == 8'h24) mask_q <= reg_wdata[3:0];
  always @(posedge clock)
    if (reg_wr && reg_addr == 8'h28) sel_q <= reg_wdata[3:0];
  sequence s_clear;
    reg_rd && reg_addr == 8'h20 && !err ##1 !timeout_q;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data outside slot");
  a_timeout_single: assert property (timeout_q |=> !timeout_q)
    else $error("timeout pulse too long");
  a_done_wins: assert property (xfer_done |=> !timeout_q)
    else $error("timeout after completion");
  a_nxm_report: assert property (&cfg_q && nxm_err && !mask_q[1]
    |-> ##2 (sel_q[1] ? nmi_q : bridge_interrupt_q)) else $error("nxm not reported");
  a_timeout_report: assert property (&cfg_q && timeout_q && !mask_q[0]
    |-> ##1 (sel_q[0] ? nmi_q : bridge_interrupt_q)) else $error("timeout not reported");
  a_read_clears: assert property (s_clear |=> !irq)
    else $error("interrupt kept after status read");
  a_route_ordinary: assert property (sel_q == 4'hF && $past(sel_q) == 4'hF
    |-> !bridge_interrupt_q) else $error("ordinary interrupt while all to nmi");
  a_route_nmi: assert property (sel_q == 4'h0 && $past(sel_q) == 4'h0
    |-> !nmi_q) else $error("nmi while all ordinary");
  a_mask_quiet: assert property (mask_q == 4'hF && $past(mask_q) == 4'hF |-> !irq)
    else $error("interrupt while masked");
endmodule
bind memory_bus_bridge bridge_err_checker chk_u (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .xfer_done(xfer_done), .nxm_err(nxm_err),
  .ca0_nxm_err(ca0_nxm_err), .ca1_nxm_err(ca1_nxm_err), .nmi_q(nmi_q),
  .bridge_interrupt_q(bridge_interrupt_q), .timeout_q(timeout_q));

// ---- tb/native_bus_model.sv ----
`timescale 1ns/1ps
module native_bus_model (
  input  wire       clock,             // Clock.
  input  wire       go,                // Begin one transfer.
  input  wire [7:0] hold,              // Cycles to completion.
  output reg        xfer_start = 1'b0, // Transfer begins.
  output reg        xfer_done  = 1'b0  // Transfer ends.
);
  reg [7:0] cnt_q = 8'h00;
  // A hold of zero never completes, which is how a hung target is modelled.
  always @(posedge clock) begin
    xfer_start <= go;
    xfer_done <= (cnt_q == 8'h01);
    if (go) cnt_q <= hold;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg         clock, rst_n, reg_wr, reg_rd, nxm_err, ca0_nxm_err, ca1_nxm_err, go;
  reg  [7:0]  reg_addr, hold;
  reg  [31:0] reg_wdata, fail_addr, fail_data, rd_v;
  reg  [3:0]  fail_region;
  reg  [2:0]  fail_port;
  wire [31:0] reg_rdata_q;
  wire        xfer_start, xfer_done, nmi_q, bridge_interrupt_q, timeout_q;
  integer     num_errors, checked, touts, i;
  memory_bus_bridge #(.TIMEOUT_CYCLES(4)) dut_u (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .xfer_start(xfer_start), .xfer_done(xfer_done),
    .nxm_err(nxm_err), .fail_addr(fail_addr), .fail_region(fail_region),
    .fail_data(fail_data), .fail_port(fail_port), .ca0_nxm_err(ca0_nxm_err),
    .ca1_nxm_err(ca1_nxm_err), .nmi_q(nmi_q), .bridge_interrupt_q(bridge_interrupt_q),
    .timeout_q(timeout_q));
  native_bus_model bus_u (.clock(clock), .go(go), .hold(hold),
    .xfer_start(xfer_start), .xfer_done(xfer_done));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (timeout_q === 1'b1) touts <= touts + 1;
  task end_sim;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rdc(input string nm, input [7:0] a, input [31:0] m, input [31:0] e);
    @(posedge clock);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata_q;
    chk(nm, e, rd_v & m);
  endtask
  // Error inputs stand for one cycle; interrupts are sampled once they settle.
  task err(input [1:0] k, input [31:0] a, input [31:0] d, input [2:0] p);
    @(posedge clock);
    {nxm_err, ca0_nxm_err, ca1_nxm_err} <= 3'h4 >> k;
    {fail_addr, fail_data, fail_region, fail_port} <= {a, d, a[3:0], p};
    @(posedge clock);
    {nxm_err, ca0_nxm_err, ca1_nxm_err} <= 3'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  initial begin
    repeat (4000) @(posedge clock);
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    {reg_wr, reg_rd, nxm_err, ca0_nxm_err, ca1_nxm_err, go, rst_n} = 7'h00;
    {reg_addr, hold, reg_wdata, fail_addr, fail_data, fail_region, fail_port} = '0;
    {num_errors, checked, touts} = 96'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    wr(8'h24, 32'h0);
    wr(8'h28, 32'h0);
    wr(8'h10, 32'h00000A00);
    rdc("region select", 8'h10, 32'h00000F00, 32'h00000A00);
    wr(8'h18, 32'h08000000);
    rdc("watchdog", 8'h18, 32'h7C000000, 32'h08000000);
    err(2'h0, 32'h12345675, 32'hCAFE0001, 3'h3);
    chk("irq lines", 32'h1, {nmi_q, bridge_interrupt_q});
    err(2'h0, 32'h00000011, 32'h0, 3'h5);
    rdc("err address", 8'h04, 32'hFFFFFFFF, 32'h12345675);
    rdc("err region", 8'h0C, 32'hF, 32'h5);
    rdc("port", 8'h00, 32'h1C00, 32'h0C00);
    rdc("nmi flag", 8'h14, 32'h4000, 32'h0);
    rdc("status", 8'h20, 32'hF, 32'h2);
    rdc("err data", 8'h08, 32'hFFFFFFFF, 32'hCAFE0001);
    wr(8'h28, 32'hF);
    err(2'h0, 32'h000000A3, 32'h5555AAAA, 3'h1);
    chk("irq lines", 32'h2, {nmi_q, bridge_interrupt_q});
    rdc("nmi flag", 8'h14, 32'h4000, 32'h4000);
    rdc("new address", 8'h04, 32'hFFFFFFFF, 32'hA3);
    rdc("err data", 8'h08, 32'hFFFFFFFF, 32'h5555AAAA);
    for (i = 0; i < 2; i = i + 1) begin
      err(i[1:0] + 2'h1, 32'h00000B00 + i, 32'h70000000 + i, 3'h0);
      rdc("cache address", {4'h3, i[0], 3'h0}, 32'hFFFFFFFF, 32'h00000B00 + i);
      rdc("cache data", {4'h3, i[0], 3'h4}, 32'hFFFFFFFF, 32'h70000000 + i);
    end
    rdc("status", 8'h20, 32'hF, 32'hE);
    wr(8'h24, 32'hF);
    err(2'h1, 32'h0, 32'h0, 3'h0);
    chk("masked irq", 32'h0, {nmi_q, bridge_interrupt_q});
    rdc("status", 8'h20, 32'hF, 32'h4);
    wr(8'h24, 32'h0);
    @(posedge clock);
    {hold, go, fail_port} <= {8'h02, 1'b1, 3'h2};
    @(posedge clock);
    go <= 1'b0;
    repeat (12) @(posedge clock);
    chk("prompt transfer", 32'h0, touts);
    {hold, go} <= {8'h00, 1'b1};
    @(posedge clock);
    go <= 1'b0;
    repeat (12) @(posedge clock);
    chk("timeouts", 32'h1, touts);
    rdc("timeout port", 8'h00, 32'h1C00, 32'h0800);
    rdc("port enabled", 8'h18, 32'h08000000, 32'h08000000);
    rdc("nmi flag", 8'h14, 32'h4000, 32'h4000);
    rdc("status", 8'h20, 32'hF, 32'h1);
    end_sim;
  end
endmodule
